// [logic/irq_pkg.sv]
package irq_pkg;

   // source count and index width
   localparam int          NUM_SOURCES    = 22;
   localparam int          IDX_W          = 5;
   localparam int          BASIC_SRC_CNT  = 6;   // sources steered by basic regs
   localparam int          EXT_REG_W      = 8;   // extended enable/priority regs

   // vector layout: base plus index times eight
   localparam int          VEC_W          = 16;
   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [15:0] VEC_BASE       = 16'h0003;
   localparam int          VEC_STEP_SHIFT = 3;   // step of eight bytes

   // fixed priority-order indices of the sources this block touches
   localparam logic [4:0]  IDX_EXT0       = 5'h00;
   localparam logic [4:0]  IDX_TIMER0     = 5'h01;
   localparam logic [4:0]  IDX_EXT1       = 5'h02;
   localparam logic [4:0]  IDX_TIMER1     = 5'h03;
   localparam int          IDX_SERIAL0    = 4;
   localparam int          IDX_COUNTER    = 9;
   localparam int          IDX_EXT6       = 18;
   localparam int          IDX_EXT7       = 19;
   localparam int          IDX_SERIAL1    = 20;
   localparam int          IDX_CRYSTAL    = 21;
   localparam int          COUNTER_MODULES = 5;

   // bit position of the global enable in the basic enable register
   localparam int          GLOBAL_EN_BIT  = 7;

   // timing: one clock to detect; the core needs four for the call
   localparam int          DETECT_CYCLES  = 1;
   localparam int          CALL_CYCLES    = 4;

   // reset values
   localparam logic [1:0]  IN_SERVICE_RST = 2'b00;
   localparam logic [15:0] VECTOR_RST     = RESET_VECTOR;

   // handler sequence, gray coded along idle-call-idle-resume
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_CALL   = 2'b01,
      ST_RESUME = 2'b10
   } handler_state_t;

   // service address of a priority-order index
   function automatic logic [VEC_W-1:0] vector_of(
      input logic [IDX_W-1:0] idx);
      return VEC_BASE + {{(VEC_W-IDX_W-VEC_STEP_SHIFT){1'b0}}, idx,
                         {VEC_STEP_SHIFT{1'b0}}};
   endfunction

endpackage

// [logic/ext_irq_flag.sv]
`timescale 1ns/1ps
// pending flag of one external interrupt input
module ext_irq_flag
   import irq_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,          // raw pin level, synchronous
   input  wire logic level_mode_i,   // 1: flag follows the pin
   input  wire logic active_high_i,  // 1: rising edge / high level active
   input  wire logic sw_set_i,       // software writes one
   input  wire logic sw_clr_i,       // software writes zero
   input  wire logic hw_clr_i,       // cleared as the core vectors
   output logic      pending_o
);

   logic pin_prev_q;   // last pin level for edge detection
   logic active_now;   // pin at its active level
   logic active_prev;  // pin was at its active level
   logic edge_seen;    // inactive-to-active transition

   assign active_now  = active_high_i ? pin_i : ~pin_i;
   assign active_prev = active_high_i ? pin_prev_q : ~pin_prev_q;
   assign edge_seen   = active_now & ~active_prev;

   // previous pin level; reset to idle-high is harmless for both senses
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pin_prev_q <= 1'b1;
      end else begin
         pin_prev_q <= pin_i;
      end
   end

   // flag update: level tracks, edge latches with set winning over clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pending_o <= 1'b0;
      end else if (level_mode_i) begin
         pending_o <= active_now;                                  // R13
      end else if (edge_seen || sw_set_i) begin
         pending_o <= 1'b1;                                        // R2
      end else if (hw_clr_i || sw_clr_i) begin
         pending_o <= 1'b0;                                        // R12
      end
   end

endmodule

// [logic/irq_priority_pick.sv]
`timescale 1ns/1ps
// two-level arbitration with fixed order inside a level
module irq_priority_pick
   import irq_pkg::*;
#(
   parameter int N = NUM_SOURCES
)(
   input  wire logic [N-1:0]     req_i,        // gated requests
   input  wire logic [N-1:0]     high_i,       // per-source high priority
   input  wire logic             allow_low_i,  // low level may be taken
   input  wire logic             allow_high_i, // high level may be taken
   output logic                  valid_o,      // a winner exists
   output logic [IDX_W-1:0]      index_o,      // winner order index
   output logic                  high_o        // winner is high level
);

   // lowest set bit wins, so index 0 is favoured
   function automatic logic [IDX_W:0] first_set(input logic [N-1:0] v);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

   logic [IDX_W:0] hi_pick;  // found flag and index among high
   logic [IDX_W:0] lo_pick;  // found flag and index among low

   assign hi_pick = first_set(req_i & high_i & {N{allow_high_i}});
   assign lo_pick = first_set(req_i & ~high_i & {N{allow_low_i}});

   // level first, order second
   always_comb begin
      if (hi_pick[IDX_W]) begin                                    // R20
         valid_o = 1'b1;
         index_o = hi_pick[IDX_W-1:0];                             // R17
         high_o  = 1'b1;
      end else begin
         valid_o = lo_pick[IDX_W];
         index_o = lo_pick[IDX_W-1:0];
         high_o  = 1'b0;
      end
   end

endmodule

// [logic/vectored_interrupt_handler.sv]
`timescale 1ns/1ps
// Behaviour
// R1: twenty-two sources, each one of two levels
// R2: valid condition sets the source pending flag
// R3: flags set regardless; disabled flags request nothing
// R4: enabled pending source forces call after instruction
// R5: core returns to next instruction on return
// R6: global enable off masks every source
// R7: each source has its own enable bit
// R8: some flags cleared on vectoring, others by software
// R9: flag still set after return re-enters later
// R10: software writing one acts as real event
// R11: ext 0/1 select low level or falling edge
// R12: edge-mode ext 0/1 flag cleared on vectoring
// R13: level-mode ext 0/1 flag follows the pin
// R14: level source holds input until recognised
// R15: ext 6/7 edge only with selectable polarity
// R16: reset vector zero; sources from three step eight
// R17: fixed order index 0..21, lower wins ties
// R18: shared vectors for serial and counter array flags
// R19: first six basic regs, rest extended regs
// R20: high pre-empts low; high never pre-empted
// R21: sample every clock; detect plus four-clock call
// R22: equal or lower waits for return plus one
// R23: request is flag and enable and global enable
module vectored_interrupt_handler
   import irq_pkg::*;
#(
   parameter int N = NUM_SOURCES
)(
   input  wire logic               sys_clk_i,
   input  wire logic               rst_n_i,
   // enable and priority registers, held by the core
   input  wire logic [7:0]         basic_enable_reg_i,
   input  wire logic [7:0]         extended_enable_reg_one_i,
   input  wire logic [7:0]         extended_enable_reg_two_i,
   input  wire logic [7:0]         basic_priority_reg_i,
   input  wire logic [7:0]         extended_priority_reg_one_i,
   input  wire logic [7:0]         extended_priority_reg_two_i,
   // external input configuration
   input  wire logic               ext0_trigger_select_i,
   input  wire logic               ext1_trigger_select_i,
   input  wire logic               ext6_polarity_i,
   input  wire logic               ext7_polarity_i,
   // external pins, synchronous to the clock
   input  wire logic               ext_irq0_n_i,
   input  wire logic               ext_irq1_n_i,
   input  wire logic               ext_irq6_i,
   input  wire logic               ext_irq7_i,
   // software writes of the four external flags: 0,1,6,7
   input  wire logic [3:0]         ext_flag_set_i,
   input  wire logic [3:0]         ext_flag_clr_i,
   // flags held inside peripherals
   input  wire logic [N-1:0]       periph_flag_i,
   input  wire logic               timer0_overflow_flag_i,
   input  wire logic               timer1_overflow_flag_i,
   input  wire logic               serial0_receive_flag_i,
   input  wire logic               serial0_transmit_flag_i,
   input  wire logic               serial1_receive_flag_i,
   input  wire logic               serial1_transmit_flag_i,
   input  wire logic               counter_array_overflow_flag_i,
   input  wire logic [4:0]         counter_module_match_flag_i,
   input  wire logic               crystal_valid_flag_i,
   // core handshake
   input  wire logic               instr_done_i,
   input  wire logic               return_from_interrupt_i,
   input  wire logic               call_done_i,
   // outputs to the core and peripherals
   output logic                    forced_long_call_o,
   output logic [VEC_W-1:0]        vector_addr_o,
   output logic                    in_service_high_o,
   output logic                    in_service_low_o,
   output logic                    timer0_overflow_clear_o,
   output logic                    timer1_overflow_clear_o,
   output logic                    ext0_pending_o,
   output logic                    ext1_pending_o,
   output logic                    ext6_pending_o,
   output logic                    ext7_pending_o
);

   // external input flags
   logic ext0_hw_clr;   // vectoring to ext0 in edge mode
   logic ext1_hw_clr;   // vectoring to ext1 in edge mode

   // ext0: trigger select one means falling edge, zero low level
   ext_irq_flag u_ext0 (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .pin_i         (ext_irq0_n_i),
      .level_mode_i  (~ext0_trigger_select_i),                     // R11
      .active_high_i (1'b0),
      .sw_set_i      (ext_flag_set_i[0]),                          // R10
      .sw_clr_i      (ext_flag_clr_i[0]),
      .hw_clr_i      (ext0_hw_clr),
      .pending_o     (ext0_pending_o)
   );

   // ext1: same behaviour as ext0
   ext_irq_flag u_ext1 (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .pin_i         (ext_irq1_n_i),
      .level_mode_i  (~ext1_trigger_select_i),                     // R11
      .active_high_i (1'b0),
      .sw_set_i      (ext_flag_set_i[1]),
      .sw_clr_i      (ext_flag_clr_i[1]),
      .hw_clr_i      (ext1_hw_clr),
      .pending_o     (ext1_pending_o)
   );

   // ext6: edge only, polarity selectable, cleared by software only
   ext_irq_flag u_ext6 (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .pin_i         (ext_irq6_i),
      .level_mode_i  (1'b0),                                       // R15
      .active_high_i (ext6_polarity_i),
      .sw_set_i      (ext_flag_set_i[2]),
      .sw_clr_i      (ext_flag_clr_i[2]),
      .hw_clr_i      (1'b0),
      .pending_o     (ext6_pending_o)
   );

   // ext7: as ext6
   ext_irq_flag u_ext7 (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .pin_i         (ext_irq7_i),
      .level_mode_i  (1'b0),                                       // R15
      .active_high_i (ext7_polarity_i),
      .sw_set_i      (ext_flag_set_i[3]),
      .sw_clr_i      (ext_flag_clr_i[3]),
      .hw_clr_i      (1'b0),
      .pending_o     (ext7_pending_o)
   );

   // pending vector, enables and priorities
   logic [N-1:0] pending;    // one flag per source, shared ones merged
   logic [N-1:0] enable;     // per-source enable bits
   logic [N-1:0] high_prio;  // per-source priority bits
   logic         global_en;  // master enable

   // gather pending flags; peripherals keep their own flags
   always_comb begin
      pending                    = periph_flag_i;                  // R2
      pending[IDX_EXT0]          = ext0_pending_o;
      pending[IDX_TIMER0]        = timer0_overflow_flag_i;
      pending[IDX_EXT1]          = ext1_pending_o;
      pending[IDX_TIMER1]        = timer1_overflow_flag_i;
      // shared vectors: any member flag requests
      pending[IDX_SERIAL0]       = serial0_receive_flag_i |
                                   serial0_transmit_flag_i;        // R18
      pending[IDX_COUNTER]       = counter_array_overflow_flag_i |
                                   (|counter_module_match_flag_i); // R18
      pending[IDX_SERIAL1]       = serial1_receive_flag_i |
                                   serial1_transmit_flag_i;
      pending[IDX_EXT6]          = ext6_pending_o;
      pending[IDX_EXT7]          = ext7_pending_o;
      pending[IDX_CRYSTAL]       = crystal_valid_flag_i;
   end

   // first six from basic regs, then the extended pair bit for bit
   assign enable    = {extended_enable_reg_two_i,
                       extended_enable_reg_one_i,
                       basic_enable_reg_i[BASIC_SRC_CNT-1:0]};     // R19 R7
   assign high_prio = {extended_priority_reg_two_i,
                       extended_priority_reg_one_i,
                       basic_priority_reg_i[BASIC_SRC_CNT-1:0]};   // R19 R1
   assign global_en = basic_enable_reg_i[GLOBAL_EN_BIT];           // R6

   // detect stage: requests sampled every clock
   logic [N-1:0] req_q;  // registered gated requests

   // a disabled flag stays pending but never reaches the arbiter
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         req_q <= '0;
      end else begin
         req_q <= pending & enable & {N{global_en}};          // R23 R3 R21
      end
   end

   // arbitration against the routines in progress
   logic             win_valid;  // a request may be taken
   logic [IDX_W-1:0] win_index;  // its order index
   logic             win_high;   // its level
   logic             allow_low;  // no routine at all in progress
   logic             allow_high; // no high routine in progress

   // high never pre-empted; low only by high
   assign allow_high = ~in_service_high_o;                         // R20
   assign allow_low  = ~in_service_high_o & ~in_service_low_o;     // R22

   irq_priority_pick #(
      .N (N)
   ) u_pick (
      .req_i        (req_q),
      .high_i       (high_prio),
      .allow_low_i  (allow_low),
      .allow_high_i (allow_high),
      .valid_o      (win_valid),
      .index_o      (win_index),
      .high_o       (win_high)
   );

   // sequencing of the forced call
   handler_state_t state_q;  // sequence state
   handler_state_t state_d;  // next sequence state
   logic           take;     // winner accepted at this boundary

   // a take needs an instruction boundary; the boundary of the return
   // itself is skipped, so one more instruction runs first
   always_comb begin
      state_d = state_q;
      take    = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (instr_done_i && return_from_interrupt_i) begin
               state_d = ST_RESUME;                                // R9
            end else if (instr_done_i && win_valid) begin
               take    = 1'b1;                                     // R4
               state_d = ST_CALL;
            end
         end
         ST_CALL: begin
            // the core spends its four clocks on the call here
            if (call_done_i) begin
               state_d = ST_IDLE;                                  // R21
            end
         end
         ST_RESUME: begin
            // the instruction after the return has now completed
            if (instr_done_i && return_from_interrupt_i) begin
               state_d = ST_RESUME;
            end else if (instr_done_i && win_valid) begin
               take    = 1'b1;                                     // R22
               state_d = ST_CALL;
            end else if (instr_done_i) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // call request and its address; address resets to the reset vector and keeps the last vector after a call
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         forced_long_call_o <= 1'b0;
         vector_addr_o      <= VECTOR_RST;                         // R16
      end else if (take) begin
         forced_long_call_o <= 1'b1;
         vector_addr_o      <= vector_of(win_index);               // R16
      end else if (state_q == ST_CALL && call_done_i) begin
         forced_long_call_o <= 1'b0;
      end
   end

   // routines in progress, one bit per level
   // a return closes the highest level open; a take opens its level
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         {in_service_high_o, in_service_low_o} <= IN_SERVICE_RST;
      end else if (take) begin
         if (win_high) begin
            in_service_high_o <= 1'b1;                             // R20
         end else begin
            in_service_low_o  <= 1'b1;
         end
      end else if (instr_done_i && return_from_interrupt_i) begin
         if (in_service_high_o) begin
            in_service_high_o <= 1'b0;                             // R5
         end else begin
            in_service_low_o  <= 1'b0;
         end
      end
   end

   // flags cleared by hardware on vectoring
   // edge-mode ext 0/1 flags only; level flags follow the pin
   assign ext0_hw_clr = take && win_index == IDX_EXT0 &&
                        ext0_trigger_select_i;                     // R12
   assign ext1_hw_clr = take && win_index == IDX_EXT1 &&
                        ext1_trigger_select_i;                     // R12

   // timer flags live in the timer; tell it with a one-cycle pulse.
   // every flag other than these and the edge-mode ext 0/1 flags is left for the routine to clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer0_overflow_clear_o <= 1'b0;
         timer1_overflow_clear_o <= 1'b0;
      end else begin
         timer0_overflow_clear_o <= take && win_index == IDX_TIMER0; // R8
         timer1_overflow_clear_o <= take && win_index == IDX_TIMER1; // R8
      end
   end

endmodule

// [dv/core_model.sv]
`timescale 1ns/1ps
// core side of the call handshake: ends each forced call after a fixed count
module core_model
   import irq_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic forced_long_call_i,
   output logic      call_done_o
);
   logic [2:0] cnt_q;   // cycles the call has stood so far
   // done on the fourth cycle of the call, never while idle
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !forced_long_call_i) begin
         cnt_q       <= 3'h0;
         call_done_o <= 1'b0;
      end else begin
         cnt_q       <= cnt_q + 3'h1;
         call_done_o <= (cnt_q == 3'(CALL_CYCLES - 2));
      end
   end
endmodule

// [dv/irq_handler_sva.sv]
`timescale 1ns/1ps
// timing relations seen at the handler ports
module irq_handler_sva
   import irq_pkg::*;
(
   input wire logic             sys_clk_i,
   input wire logic             rst_n_i,
   input wire logic [7:0]       basic_enable_reg_i,
   input wire logic             ext0_trigger_select_i,
   input wire logic             ext_irq0_n_i,
   input wire logic             instr_done_i,
   input wire logic             return_from_interrupt_i,
   input wire logic             call_done_i,
   input wire logic             forced_long_call_o,
   input wire logic [VEC_W-1:0] vector_addr_o,
   input wire logic             in_service_high_o,
   input wire logic             in_service_low_o,
   input wire logic             timer0_overflow_clear_o,
   input wire logic             ext0_pending_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_call_has_cause: assert property ($rose(forced_long_call_o) |->
      $past(instr_done_i) && !$past(return_from_interrupt_i)
      && $past(basic_enable_reg_i[GLOBAL_EN_BIT], 2)) else $error("bad take");
   a_vector_form: assert property ($rose(forced_long_call_o) |->
      vector_addr_o[2:0] == 3'h3 && vector_addr_o <= 16'h00AB)
      else $error("bad vector");
   a_call_holds: assert property (forced_long_call_o && !call_done_i |=>
      forced_long_call_o && $stable(vector_addr_o)) else $error("call lost");
   a_call_ends: assert property (forced_long_call_o && call_done_i |=>
      !forced_long_call_o) else $error("call stuck");
   a_service_opens: assert property ($rose(forced_long_call_o) |->
      in_service_high_o || in_service_low_o) else $error("no service");
   a_return_closes: assert property (instr_done_i && return_from_interrupt_i
      && in_service_high_o |=> !in_service_high_o) else $error("high open");
   a_no_take_ret: assert property (instr_done_i && return_from_interrupt_i
      && !forced_long_call_o |=> !forced_long_call_o) else $error("early take");
   a_timer_clear: assert property (timer0_overflow_clear_o |->
      $rose(forced_long_call_o) && vector_addr_o == 16'h000B)
      else $error("stray clear");
   a_edge_sets: assert property (ext0_trigger_select_i && !instr_done_i
      && $fell(ext_irq0_n_i) |=> ext0_pending_o) else $error("edge missed");
   a_level_tracks: assert property (!ext0_trigger_select_i |=>
      ext0_pending_o == !$past(ext_irq0_n_i)) else $error("level flag");
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
   import irq_pkg::*;
   logic       sys_clk_i, rst_n_i, trig0, trig1, pol6, pol7;
   logic       pin0_n, pin1_n, pin6, pin7, t0, t1, s0r, s0t, s1r, s1t;
   logic       cf, xv, instr, ret, cdone, call, ish, isl, t0c, t1c;
   logic       p0, p1, p6, p7;
   logic [7:0] en_b, en_1, en_2, pr_b, pr_1, pr_2;
   logic [3:0] fset, fclr;
   logic [4:0] ccf;
   logic [NUM_SOURCES-1:0] pflag;
   logic [VEC_W-1:0]       vec;
   int         bad_count, comparisons;
   int         idx [8] = '{1, 3, 4, 6, 9, 14, 20, 21};  // mixed enable regs
   always #5 sys_clk_i = ~sys_clk_i;
   vectored_interrupt_handler u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .basic_enable_reg_i(en_b), .extended_enable_reg_one_i(en_1),
      .extended_enable_reg_two_i(en_2), .basic_priority_reg_i(pr_b),
      .extended_priority_reg_one_i(pr_1), .extended_priority_reg_two_i(pr_2),
      .ext0_trigger_select_i(trig0), .ext1_trigger_select_i(trig1),
      .ext6_polarity_i(pol6), .ext7_polarity_i(pol7), .ext_irq0_n_i(pin0_n),
      .ext_irq1_n_i(pin1_n), .ext_irq6_i(pin6), .ext_irq7_i(pin7),
      .ext_flag_set_i(fset), .ext_flag_clr_i(fclr), .periph_flag_i(pflag),
      .timer0_overflow_flag_i(t0), .timer1_overflow_flag_i(t1),
      .serial0_receive_flag_i(s0r), .serial0_transmit_flag_i(s0t),
      .serial1_receive_flag_i(s1r), .serial1_transmit_flag_i(s1t),
      .counter_array_overflow_flag_i(cf), .counter_module_match_flag_i(ccf),
      .crystal_valid_flag_i(xv), .instr_done_i(instr),
      .return_from_interrupt_i(ret), .call_done_i(cdone),
      .forced_long_call_o(call), .vector_addr_o(vec),
      .in_service_high_o(ish), .in_service_low_o(isl),
      .timer0_overflow_clear_o(t0c), .timer1_overflow_clear_o(t1c),
      .ext0_pending_o(p0), .ext1_pending_o(p1), .ext6_pending_o(p6),
      .ext7_pending_o(p7));
   core_model u_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .forced_long_call_i(call), .call_done_o(cdone));
   // inputs change one nanosecond after the rising edge
   task automatic tick;
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // idle edge first, so back-to-back boundaries never reassign instr
   task automatic step(logic r);
      tick;
      instr = 1'b1;
      ret   = r;
      tick;
      instr = 1'b0;
      ret   = 1'b0;
   endtask
   // boundary that must take at once, then wait out the call
   task automatic serve(logic [15:0] exp);
      int n;
      step(1'b0);
      check("call", 1'b1, call);
      check("vector", exp, vec);
      check("clears", {exp == 16'h001B, exp == 16'h000B}, {t1c, t0c});
      n = 0;
      while (call === 1'b1 && n < 20) begin
         tick;
         n++;
      end
      check("call end", 1'b0, call);
   endtask
   task automatic no_call;
      step(1'b0);
      check("no call", 1'b0, call);
   endtask
   // drive the flag of one order index
   task automatic src(int k, logic v);
      case (k)
         1: t0 = v;
         3: t1 = v;
         4: s0t = v;
         9: ccf[2] = v;
         20: s1r = v;
         21: xv = v;
         default: pflag[k] = v;
      endcase
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // cut a hang short well beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      bad_count++;
      report_and_stop;
   end
   initial begin
      {sys_clk_i, rst_n_i, trig0, trig1, pol6, pol7, pin6, pin7} = '0;
      {t0, t1, s0r, s0t, s1r, s1t, cf, xv, instr, ret} = '0;
      {en_b, en_1, en_2, pr_b, pr_1, pr_2, fset, fclr, ccf, pflag} = '0;
      {pin0_n, pin1_n, pin6, pol7} = 4'b1111; // pins idle inactive
      repeat (6) tick;
      rst_n_i = 1'b1;
      tick;
      check("reset vector", 16'h0000, vec);
      // edge flag set with global enable off, no request
      en_b  = 8'h01;
      {trig0, trig1, pin0_n, pin1_n} = 4'b1100;
      repeat (2) tick;
      check("ext0/1 flags", 2'b11, {p1, p0});
      no_call;
      en_b = 8'h81;
      tick;
      serve(16'h0003);
      check("ext flags", 2'b10, {p1, p0});
      step(1'b1);
      // level mode: flags follow the pins, no clear on vectoring
      {trig0, trig1, pin1_n} = 3'b001;
      repeat (2) tick;
      check("ext0 level", 1'b1, p0);
      serve(16'h0003);
      pin0_n = 1'b1;
      repeat (2) tick;
      check("ext level off", 2'b00, {p1, p0});
      step(1'b1);
      no_call;
      // eight sources, all enable bits set, each through its own vector
      en_b = 8'hBF;
      en_1 = 8'hFF;
      en_2 = 8'hFF;
      foreach (idx[i]) begin
         src(idx[i], 1'b1);
         repeat (2) tick;
         serve(VEC_BASE + 16'(idx[i] * 8));
         src(idx[i], 1'b0);
         step(1'b1);
      end
      // software set on an edge-only input, real edge on the other
      fset = 4'b0100;
      tick;
      fset = 4'b0000;
      tick;
      check("ext6 flag", 1'b1, p6);
      serve(16'h0093);
      fclr = 4'b0100;
      {pol7, pin7} = 2'b11;
      tick;
      fclr = 4'b1000;
      check("ext7 and ext6", 2'b10, {p7, p6});
      tick;
      fclr = 4'b0000;
      check("ext7 clear", 1'b0, p7);
      step(1'b1);
      // flag left set over the return comes back one boundary later
      src(6, 1'b1);
      repeat (2) tick;
      serve(16'h0033);
      step(1'b1);
      check("no take at return", 1'b0, call);
      serve(16'h0033);
      src(6, 1'b0);
      step(1'b1);
      // high level wins and blocks; low waits; high pre-empts low
      pr_b = 8'h20;
      src(3, 1'b1);
      src(5, 1'b1);
      repeat (2) tick;
      serve(16'h002B);
      check("high open", 1'b1, ish);
      no_call;
      src(5, 1'b0);
      step(1'b1);
      serve(16'h001B);
      check("low open", 1'b1, isl);
      src(5, 1'b1);
      repeat (2) tick;
      serve(16'h002B);
      src(5, 1'b0);
      src(3, 1'b0);
      step(1'b1);
      step(1'b1);
      report_and_stop;
   end
endmodule
bind vectored_interrupt_handler irq_handler_sva u_sva (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .basic_enable_reg_i(basic_enable_reg_i),
   .ext0_trigger_select_i(ext0_trigger_select_i),
   .ext_irq0_n_i(ext_irq0_n_i), .instr_done_i(instr_done_i),
   .return_from_interrupt_i(return_from_interrupt_i),
   .call_done_i(call_done_i), .forced_long_call_o(forced_long_call_o),
   .vector_addr_o(vector_addr_o), .in_service_high_o(in_service_high_o),
   .in_service_low_o(in_service_low_o),
   .timer0_overflow_clear_o(timer0_overflow_clear_o),
   .ext0_pending_o(ext0_pending_o));
